// ### design/hcs_ebus_seq.sv
// Expansion bus access sequencer with stretched address and data phases.
// Assumes tick_in is a one-cycle enable at the expansion clock rate.
`timescale 1ns/1ps
module hcs_ebus_seq (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic style_in,
  input wire logic [1:0] ebus_addr_phase_stretch_in,
  input wire logic [2:0] ebus_data_phase_stretch_in,
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic grant_in,
  input wire logic [31:0] ad_in,
  output logic req_out,
  output logic [31:0] ad_out,
  output logic ad_oe_n_out,
  output logic addr_strobe_n_out,
  output logic rw_n_out,
  output logic wr_n_out,
  output logic ds_n_out,
  output logic [31:0] rdata_out,
  output logic done_out
);
  hcs_pkg::hcs_eb_t state_ff;
  logic [2:0] cnt_ff;
  logic wr_ff;
  logic [31:0] wdata_ff;

  // ==========================================================================
  // Phase sequencing on expansion clock ticks
  always_ff @(posedge clk_in)
  begin
    done_out <= 1'b0;
    if (rst_in)
    begin
      state_ff <= hcs_pkg::EB_IDLE;
      cnt_ff <= 3'h0;
      wr_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      req_out <= 1'b0;
      ad_out <= 32'h00000000;
      ad_oe_n_out <= 1'b1;
      addr_strobe_n_out <= 1'b1;
      rw_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      ds_n_out <= 1'b1;
      rdata_out <= 32'h00000000;
    end
    else
    begin
      case (state_ff)
        hcs_pkg::EB_IDLE:
        begin
          if (start_in)
          begin
            wr_ff <= write_in;
            wdata_ff <= wdata_in;
            ad_out <= addr_in;
            req_out <= 1'b1; // Bus request or hold request
            state_ff <= hcs_pkg::EB_REQ;
          end
        end
        hcs_pkg::EB_REQ:
        begin
          if (tick_in && grant_in)
          begin
            ad_oe_n_out <= 1'b0;
            rw_n_out <= style_in | ~wr_ff;
            cnt_ff <= 3'h0;
            state_ff <= hcs_pkg::EB_ADDR;
          end
        end
        hcs_pkg::EB_ADDR:
        begin
          if (tick_in)
          begin
            if (cnt_ff == {1'b0, ebus_addr_phase_stretch_in})
            begin
              addr_strobe_n_out <= 1'b0; // AS or ALE
              cnt_ff <= 3'h0;
              ad_out <= wdata_ff;
              ad_oe_n_out <= ~wr_ff;
              state_ff <= hcs_pkg::EB_DATA;
            end
            else
            begin
              cnt_ff <= cnt_ff + 3'h1;
            end
          end
        end
        hcs_pkg::EB_DATA:
        begin
          if (tick_in)
          begin
            addr_strobe_n_out <= 1'b1;
            if (cnt_ff == ebus_data_phase_stretch_in)
            begin
              ds_n_out <= style_in & wr_ff;
              wr_n_out <= ~(style_in & wr_ff);
              state_ff <= hcs_pkg::EB_DSTB;
            end
            else
            begin
              cnt_ff <= cnt_ff + 3'h1;
            end
          end
        end
        hcs_pkg::EB_DSTB:
        begin
          if (tick_in)
          begin
            if (!wr_ff)
            begin
              rdata_out <= ad_in;
            end
            ds_n_out <= 1'b1;
            wr_n_out <= 1'b1;
            rw_n_out <= 1'b1;
            ad_oe_n_out <= 1'b1;
            req_out <= 1'b0;
            done_out <= 1'b1;
            state_ff <= hcs_pkg::EB_IDLE;
          end
        end
        default:
        begin
          state_ff <= hcs_pkg::EB_IDLE;
        end
      endcase
    end
  end
endmodule : hcs_ebus_seq

// ### design/hcs_host_cfg.sv
// Host configuration registers, service requests and bus-master addressing.
// Assumes an APB master and channel groups that report completion per group.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Style bit 0: request/grant, address strobe, read/write line, data strobe.
// - Style bit 1: hold/acknowledge, address latch, write strobe, data strobe.
// - Address held for address stretch plus one expansion clocks, then strobed.
// - Data held for data stretch plus one expansion clocks before data strobes.
// - Interrupt line A mask bit 0 passes the line, 1 blocks it.
// - Interrupt line B mask bit 0 passes the line, 1 blocks it.
// - Mapping 0: each serial port feeds the group of the same index.
// - Mapping 1: port n feeds groups 2n and 2n+1.
// - Mapping 2: port 0 feeds groups 0-3, port 1 groups 4-7; 3 reserved.
// - Master cycles single-address while upper base is zero, dual otherwise.
// - Single-address: one clock of address with the access command.
// - Dual-address: two clocks, dual command first, access command second.
// - Dual-address cycles take the upper address word from the upper base.
// - As target, answer only single-address cycles, ignore dual-address ones.
// - Group base supplies bits 31:11 of a 2 kB aligned descriptor address.
// - Low eleven bits of each group base read as zero.
// - One service request register per channel group.
// - Completed requests post an acknowledge event; soft chip reset gets none.
// - Soft chip reset takes effect within two line clock periods.
// - One outstanding request per group; acknowledges carry the group id.
// - Opcode decode: 0,1,2,4,5,8,9,10 defined; 3,6,7 reserved.
module hcs_host_cfg #(
  parameter int GROUPS = hcs_pkg::NUM_GROUPS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic irq_a_src_in,
  input wire logic irq_b_src_in,
  output logic irq_a_out,
  output logic irq_b_out,
  output logic [3*GROUPS-1:0] grp_port_out,
  output logic [32*GROUPS-1:0] grp_desc_addr_out,
  output logic [GROUPS-1:0] grp_cmd_valid_out,
  output logic [4:0] grp_cmd_opcode_out,
  input wire logic [GROUPS-1:0] grp_done_in,
  output logic request_ack_event_out,
  output logic [2:0] ack_group_out,
  output logic soft_reset_out,
  input wire logic mst_req_in,
  input wire logic [31:0] mst_addr_in,
  input wire logic [3:0] mst_cmd_in,
  output logic [31:0] mst_ad_out,
  output logic [3:0] mst_cbe_out,
  output logic mst_addr_phase_out,
  output logic mst_done_out,
  input wire logic tgt_addr_phase_in,
  input wire logic [3:0] tgt_cbe_in,
  output logic tgt_claim_out,
  input wire logic eb_start_in,
  input wire logic eb_write_in,
  input wire logic [31:0] eb_addr_in,
  input wire logic [31:0] eb_wdata_in,
  input wire logic eb_grant_in,
  input wire logic [31:0] eb_ad_in,
  output logic eb_req_out,
  output logic [31:0] eb_ad_out,
  output logic eb_ad_oe_n_out,
  output logic eb_addr_strobe_n_out,
  output logic eb_rw_n_out,
  output logic eb_wr_n_out,
  output logic eb_ds_n_out,
  output logic [31:0] eb_rdata_out,
  output logic eb_done_out
);
  // ==========================================================================
  // Helpers
  function automatic logic [2:0] port_of(input logic [1:0] map, input int g);
    logic [2:0] gi;
    gi = g[2:0];
    case (map)
      hcs_pkg::PMAP_PAIR: port_of = {1'b0, gi[2:1]};
      hcs_pkg::PMAP_QUAD: port_of = {2'b00, gi[2]};
      default: port_of = gi; // Reserved value behaves as direct
    endcase
  endfunction : port_of

  function automatic logic op_known(input logic [4:0] op);
    case (op)
      hcs_pkg::OP_NOP, hcs_pkg::OP_CHIP_RST, hcs_pkg::OP_GRP_RST,
      hcs_pkg::OP_GLB_INIT, hcs_pkg::OP_GRP_INIT, hcs_pkg::OP_CH_ACT,
      hcs_pkg::OP_CH_DEACT, hcs_pkg::OP_JUMP: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase
  endfunction : op_known

  logic [31:0] gcfg_ff;
  logic [31:0] ubase_ff;
  logic [20:0] gbase_ff [GROUPS];
  logic [4:0] request_opcode_op_ff [GROUPS];
  logic [GROUPS-1:0] pending_ff;
  logic [GROUPS-1:0] done_ff;
  logic srst;
  logic acc;
  logic wr_acc;
  logic [31:0] rd_val;
  logic rd_ok;
  logic ebus_tick;
  logic [7:0] ediv_ff;
  hcs_pkg::hcs_mst_t mst_ff;
  logic [31:0] mst_addr_ff;
  logic [3:0] mst_cmd_ff;

  assign srst = rst_in | soft_reset_out;
  assign acc = psel_in & penable_in & pready_out;
  assign wr_acc = acc & pwrite_in;

  // ==========================================================================
  // APB slave: one wait state, error on unmapped offsets
  always_comb
  begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    if (paddr_in == hcs_pkg::OFF_GCFG)
      rd_val = gcfg_ff;
    else if (paddr_in == hcs_pkg::OFF_UBASE)
      rd_val = ubase_ff;
    else if (paddr_in == hcs_pkg::OFF_STAT)
      rd_val = {16'h0000, done_ff, pending_ff};
    else if (paddr_in[11:6] == hcs_pkg::OFF_GBASE0[11:6] && paddr_in[5:2] < 4'(GROUPS)
             && paddr_in[1:0] == 2'b00)
      rd_val = {gbase_ff[paddr_in[4:2]], 11'h000};
    else if (paddr_in[11:6] == hcs_pkg::OFF_SREQ0[11:6] && paddr_in[5:2] < 4'(GROUPS)
             && paddr_in[1:0] == 2'b00)
      rd_val = {19'h00000, request_opcode_op_ff[paddr_in[4:2]], 8'h00};
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pready_out <= 1'b0;
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= psel_in & penable_in & ~pready_out;
      prdata_out <= (psel_in & penable_in & ~pwrite_in) ? rd_val : 32'h00000000;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~rd_ok;
    end
  end

  // ==========================================================================
  // Configuration registers; a soft chip reset clears them like a reset
  always_ff @(posedge clk_in)
  begin
    if (srst)
    begin
      gcfg_ff <= hcs_pkg::GCFG_RESET;
      ubase_ff <= hcs_pkg::UBASE_RESET;
      for (int g = 0; g < GROUPS; g++)
        gbase_ff[g] <= hcs_pkg::GBASE_RESET[31:11];
    end
    else if (wr_acc && rd_ok)
    begin
      if (paddr_in == hcs_pkg::OFF_GCFG)
        gcfg_ff <= pwdata_in & hcs_pkg::GCFG_WMASK;
      if (paddr_in == hcs_pkg::OFF_UBASE)
        ubase_ff <= pwdata_in;
      if (paddr_in[11:6] == hcs_pkg::OFF_GBASE0[11:6])
        gbase_ff[paddr_in[4:2]] <= pwdata_in[31:11];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      grp_port_out <= '0;
      grp_desc_addr_out <= '0;
      irq_a_out <= 1'b0;
      irq_b_out <= 1'b0;
    end
    else
    begin
      for (int g = 0; g < GROUPS; g++)
      begin
        grp_port_out[3*g +: 3] <= port_of(gcfg_ff[1:0], g);
        grp_desc_addr_out[32*g +: 32] <= {gbase_ff[g], 11'h000};
      end
      irq_a_out <= irq_a_src_in & ~gcfg_ff[hcs_pkg::GC_INTA_MSK];
      irq_b_out <= irq_b_src_in & ~gcfg_ff[hcs_pkg::GC_INTB_MSK];
    end
  end

  // ==========================================================================
  // Service requests and acknowledge events
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      soft_reset_out <= 1'b0;
    else
      soft_reset_out <= wr_acc && paddr_in[11:6] == hcs_pkg::OFF_SREQ0[11:6] && rd_ok
                        && pwdata_in[12:8] == hcs_pkg::OP_CHIP_RST;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst)
    begin
      pending_ff <= '0;
      done_ff <= '0;
      grp_cmd_valid_out <= '0;
      grp_cmd_opcode_out <= 5'h00;
      request_ack_event_out <= 1'b0;
      ack_group_out <= 3'h0;
      for (int g = 0; g < GROUPS; g++)
        request_opcode_op_ff[g] <= hcs_pkg::OP_NOP;
    end
    else
    begin
      grp_cmd_valid_out <= '0;
      request_ack_event_out <= 1'b0;
      for (int g = 0; g < GROUPS; g++)
      begin
        // Group completion sets done; done is only cleared once posted
        if (grp_done_in[g] && pending_ff[g])
          done_ff[g] <= 1'b1;
      end
      for (int g = GROUPS - 1; g >= 0; g--)
      begin
        if (done_ff[g])
        begin
          request_ack_event_out <= 1'b1;
          ack_group_out <= g[2:0];
        end
      end
      for (int g = 0; g < GROUPS; g++)
      begin
        if (done_ff[g] && (done_ff & GROUPS'((1 << g) - 1)) == '0)
        begin
          done_ff[g] <= 1'b0;
          pending_ff[g] <= 1'b0;
        end
      end
      if (wr_acc && rd_ok && paddr_in[11:6] == hcs_pkg::OFF_SREQ0[11:6]
          && !pending_ff[paddr_in[4:2]])
      begin
        request_opcode_op_ff[paddr_in[4:2]] <= pwdata_in[12:8];
        if (pwdata_in[12:8] != hcs_pkg::OP_CHIP_RST)
        begin
          pending_ff[paddr_in[4:2]] <= 1'b1;
          if (op_known(pwdata_in[12:8]) && pwdata_in[12:8] != hcs_pkg::OP_NOP)
          begin
            grp_cmd_valid_out[paddr_in[4:2]] <= 1'b1;
            grp_cmd_opcode_out <= pwdata_in[12:8];
          end
          else
            done_ff[paddr_in[4:2]] <= 1'b1; // No-op and reserved finish at once
        end
      end
    end
  end

  // ==========================================================================
  // Bus-master address phase and target decode
  always_ff @(posedge clk_in)
  begin
    mst_done_out <= 1'b0;
    if (rst_in)
    begin
      mst_ff <= hcs_pkg::MST_IDLE;
      mst_ad_out <= 32'h00000000;
      mst_cbe_out <= 4'h0;
      mst_addr_phase_out <= 1'b0;
      mst_addr_ff <= 32'h00000000;
      mst_cmd_ff <= 4'h0;
      tgt_claim_out <= 1'b0;
    end
    else
    begin
      tgt_claim_out <= tgt_addr_phase_in && tgt_cbe_in != hcs_pkg::PCI_CMD_DAC;
      case (mst_ff)
        hcs_pkg::MST_IDLE:
        begin
          mst_addr_phase_out <= 1'b0;
          if (mst_req_in)
          begin
            mst_addr_ff <= mst_addr_in;
            mst_cmd_ff <= mst_cmd_in;
            mst_addr_phase_out <= 1'b1;
            mst_ad_out <= mst_addr_in;
            if (ubase_ff != 32'h00000000)
            begin
              mst_cbe_out <= hcs_pkg::PCI_CMD_DAC;
              mst_ff <= hcs_pkg::MST_DAC;
            end
            else
            begin
              mst_cbe_out <= mst_cmd_in;
              mst_ff <= hcs_pkg::MST_ADR;
            end
          end
        end
        hcs_pkg::MST_DAC:
        begin
          mst_ad_out <= ubase_ff;
          mst_cbe_out <= mst_cmd_ff;
          mst_ff <= hcs_pkg::MST_ADR;
        end
        hcs_pkg::MST_ADR:
        begin
          mst_addr_phase_out <= 1'b0;
          mst_done_out <= 1'b1;
          mst_ff <= hcs_pkg::MST_IDLE;
        end
        default:
          mst_ff <= hcs_pkg::MST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Expansion bus clock enable and sequencer
  always_ff @(posedge clk_in)
  begin
    if (rst_in || ediv_ff == 8'(hcs_pkg::EBUS_DIV - 1))
      ediv_ff <= 8'h00;
    else
      ediv_ff <= ediv_ff + 8'h01;
  end
  assign ebus_tick = (ediv_ff == 8'(hcs_pkg::EBUS_DIV - 1));

  hcs_ebus_seq u_ebus (
    .clk_in(clk_in),
    .rst_in(srst),
    .tick_in(ebus_tick),
    .style_in(gcfg_ff[hcs_pkg::GC_STYLE]),
    .ebus_addr_phase_stretch_in(gcfg_ff[hcs_pkg::GC_EBUS_ADDR_PHASE_STRETCH_LO +: 2]),
    .ebus_data_phase_stretch_in(gcfg_ff[hcs_pkg::GC_EBUS_DATA_PHASE_STRETCH_LO +: 3]),
    .start_in(eb_start_in),
    .write_in(eb_write_in),
    .addr_in(eb_addr_in),
    .wdata_in(eb_wdata_in),
    .grant_in(eb_grant_in),
    .ad_in(eb_ad_in),
    .req_out(eb_req_out),
    .ad_out(eb_ad_out),
    .ad_oe_n_out(eb_ad_oe_n_out),
    .addr_strobe_n_out(eb_addr_strobe_n_out),
    .rw_n_out(eb_rw_n_out),
    .wr_n_out(eb_wr_n_out),
    .ds_n_out(eb_ds_n_out),
    .rdata_out(eb_rdata_out),
    .done_out(eb_done_out)
  );

  // ==========================================================================
  // Assertions
  inta_mask_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(gcfg_ff[3]) |-> !irq_a_out) else $error("masked line A asserted");
  intb_mask_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (!$past(gcfg_ff[2]) && $past(irq_b_src_in)) |-> irq_b_out)
    else $error("line B not passed");
  sac_phase_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (mst_ff == hcs_pkg::MST_IDLE && mst_req_in && ubase_ff == 32'h0) |=>
    mst_cbe_out == $past(mst_cmd_in) ##1 !mst_addr_phase_out)
    else $error("single address phase wrong");
  dac_phase_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (mst_ff == hcs_pkg::MST_IDLE && mst_req_in && ubase_ff != 32'h0) |=>
    mst_cbe_out == hcs_pkg::PCI_CMD_DAC ##1 mst_addr_phase_out)
    else $error("dual address phase wrong");
  dac_upper_a: assert property (@(posedge clk_in) disable iff (rst_in)
    mst_ff == hcs_pkg::MST_DAC |=> mst_ad_out == $past(ubase_ff))
    else $error("upper address not from base");
  tgt_dac_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (tgt_addr_phase_in && tgt_cbe_in == hcs_pkg::PCI_CMD_DAC) |=> !tgt_claim_out)
    else $error("dual address cycle claimed");
  gbase_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (pready_out && paddr_in[11:6] == 6'h01 && !pwrite_in) |-> prdata_out[10:0] == 11'h000)
    else $error("group base low bits set");
  pmap_pair_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(gcfg_ff[1:0]) == 2'h1 |-> grp_port_out[17:15] == 3'h2)
    else $error("pair mapping wrong");
  chip_rst_a: assert property (@(posedge clk_in) disable iff (rst_in)
    soft_reset_out |=> gcfg_ff == 32'h0 && pending_ff == '0 && !request_ack_event_out)
    else $error("soft reset not applied");
  nop_ack_a: assert property (@(posedge clk_in) disable iff (srst)
    (wr_acc && paddr_in == 12'h080 && pwdata_in[12:8] == 5'h00 && !pending_ff[0]
     && done_ff == '0) |=> ##1 request_ack_event_out && ack_group_out == 3'h0)
    else $error("no-op not acknowledged");
  dac_cov: cover property (@(posedge clk_in) mst_ff == hcs_pkg::MST_DAC);
  ack_cov: cover property (@(posedge clk_in) request_ack_event_out && ack_group_out == 3'h7);
  srst_cov: cover property (@(posedge clk_in) soft_reset_out);
endmodule : hcs_host_cfg

// ### design/hcs_pkg.sv
// Constants for the host configuration and service request block.
// Assumes a single 50 MHz clock and an APB register bus with 32-bit data.
package hcs_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFF_GCFG = 12'h000;
  localparam logic [11:0] OFF_UBASE = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_GBASE0 = 12'h040;
  localparam logic [11:0] OFF_SREQ0 = 12'h080;
  localparam int NUM_GROUPS = 8;
  // ==========================================================================
  // Global configuration fields
  localparam int GC_STYLE = 10;
  localparam int GC_EBUS_ADDR_PHASE_STRETCH_LO = 8;
  localparam int GC_EBUS_DATA_PHASE_STRETCH_LO = 4;
  localparam int GC_INTA_MSK = 3;
  localparam int GC_INTB_MSK = 2;
  localparam int GC_PMAP_LO = 0;
  localparam logic [31:0] GCFG_WMASK = 32'h0000077F;
  localparam logic [31:0] GCFG_RESET = 32'h00000000;
  localparam logic [31:0] UBASE_RESET = 32'h00000000;
  localparam logic [31:0] GBASE_WMASK = 32'hFFFFF800;
  localparam logic [31:0] GBASE_RESET = 32'h00000000;
  localparam int REQUEST_OPCODE_OP_LO = 8;
  localparam int REQUEST_OPCODE_OP_W = 5;
  // ==========================================================================
  // Request opcodes
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_CHIP_RST = 5'h01;
  localparam logic [4:0] OP_GRP_RST = 5'h02;
  localparam logic [4:0] OP_GLB_INIT = 5'h04;
  localparam logic [4:0] OP_GRP_INIT = 5'h05;
  localparam logic [4:0] OP_CH_ACT = 5'h08;
  localparam logic [4:0] OP_CH_DEACT = 5'h09;
  localparam logic [4:0] OP_JUMP = 5'h0A;
  // ==========================================================================
  // Bus master commands and timing
  localparam logic [3:0] PCI_CMD_DAC = 4'hD;
  localparam int CLK_HZ = 50000000;
  localparam int EBUS_HZ = 25000000;
  localparam int EBUS_DIV = CLK_HZ / EBUS_HZ;
  localparam logic [1:0] PMAP_DIRECT = 2'h0;
  localparam logic [1:0] PMAP_PAIR = 2'h1;
  localparam logic [1:0] PMAP_QUAD = 2'h2;

  typedef enum logic [2:0] {
    MST_IDLE = 3'b001,
    MST_DAC = 3'b010,
    MST_ADR = 3'b100
  } hcs_mst_t;

  typedef enum logic [4:0] {
    EB_IDLE = 5'b00001,
    EB_REQ = 5'b00010,
    EB_ADDR = 5'b00100,
    EB_DATA = 5'b01000,
    EB_DSTB = 5'b10000
  } hcs_eb_t;
endpackage : hcs_pkg

// ### testbench/hcs_group_model.sv
// Channel group model: answers each command pulse with a one-cycle done pulse.
// Assumes command pulses last one cycle; odd groups answer slower than even ones.
`timescale 1ns/1ps
module hcs_group_model #(
  parameter int LAT = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] cmd_valid_in,
  output logic [7:0] done_out
);
  logic [7:0] pipe_ff [0:LAT-1];

  // ==========================================================
  // Delay line of command pulses
  always_ff @(posedge clk_in)
  begin
    pipe_ff[0] <= rst_in ? 8'h00 : cmd_valid_in;
    for (int i = 1; i < LAT; i++)
      pipe_ff[i] <= rst_in ? 8'h00 : pipe_ff[i-1];
  end

  assign done_out = (pipe_ff[1] & 8'h55) | (pipe_ff[LAT-1] & 8'hAA);
endmodule : hcs_group_model

// ### testbench/test_host_config_and_service_requests.sv
// Self-checking bench for the host configuration block, driven over APB.
// Assumes a 50 MHz clock and the channel group model answering commands.
`timescale 1ns/1ps
module test_host_config_and_service_requests;
  logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic irq_a_src_in = 0, irq_b_src_in = 0, mst_req_in = 0, tgt_addr_phase_in = 0;
  logic eb_start_in = 0, eb_write_in = 1, eb_grant_in = 1;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, mst_addr_in = 0, eb_addr_in = 32'h00000040;
  logic [31:0] eb_wdata_in = 32'h0000005A, eb_ad_in = 32'h00000000, rd;
  logic [3:0] mst_cmd_in = 0, tgt_cbe_in = 0;
  logic [7:0] grp_done_in, grp_cmd_valid_out, acks = 0;
  logic [31:0] prdata_out, mst_ad_out, eb_ad_out, eb_rdata_out;
  logic [23:0] grp_port_out;
  logic [255:0] grp_desc_addr_out;
  logic [4:0] grp_cmd_opcode_out;
  logic [3:0] mst_cbe_out;
  logic [2:0] ack_group_out;
  logic pready_out, pslverr_out, irq_a_out, irq_b_out, request_ack_event_out, soft_reset_out;
  logic mst_addr_phase_out, mst_done_out, tgt_claim_out, eb_req_out, eb_ad_oe_n_out;
  logic eb_addr_strobe_n_out, eb_rw_n_out, eb_wr_n_out, eb_ds_n_out, eb_done_out, err;
  logic [4:0] ops [8] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09, 5'h0A};
  int fails = 0, checked = 0, cycles = 0, ackn = 0, srst = 0, n;

  hcs_host_cfg DUT (.*);
  hcs_group_model partner (.clk_in(clk_in), .rst_in(rst_in),
    .cmd_valid_in(grp_cmd_valid_out), .done_out(grp_done_in));

  always #10 clk_in = ~clk_in;

  // ==========================================================
  // Event recorders and hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (request_ack_event_out === 1'b1)
    begin
      acks[ack_group_out] <= 1'b1;
      ackn++;
    end
    if (soft_reset_out === 1'b1)
      srst++;
    if (cycles == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    // Let an edge pass so a following call never reassigns psel in this step
    @(posedge clk_in);
  endtask : apb

  task automatic mst(input logic [31:0] ub);
    apb(1'b1, hcs_pkg::OFF_UBASE, ub);
    mst_req_in <= 1'b1;
    mst_addr_in <= ~ub;
    mst_cmd_in <= 4'h7;
    @(posedge clk_in);
    mst_req_in <= 1'b0;
    while (mst_addr_phase_out !== 1'b1) @(posedge clk_in);
    chk("cbe1", (ub != 0) ? 32'(hcs_pkg::PCI_CMD_DAC) : 32'h7, 32'(mst_cbe_out));
    chk("ad1", ~ub, mst_ad_out);
    @(posedge clk_in);
    chk("dual", 32'(ub != 0), 32'(mst_addr_phase_out));
    chk("mdone", 32'(ub == 0), 32'(mst_done_out));
    if (ub != 0)
    begin
      chk("cbe2", 32'h7, 32'(mst_cbe_out));
      chk("ad2", ub, mst_ad_out);
    end
  endtask : mst

  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    apb(1'b0, hcs_pkg::OFF_GCFG, 0);
    chk("gcfg", hcs_pkg::GCFG_RESET, rd);
    apb(1'b1, hcs_pkg::OFF_GCFG, 32'hFFFFFFFF);
    apb(1'b0, hcs_pkg::OFF_GCFG, 0);
    chk("gcfg", 32'h0000077F, rd);
    apb(1'b1, 12'hFFC, 0);
    chk("slverr", 1, 32'(err));
    irq_a_src_in <= 1'b1;
    irq_b_src_in <= 1'b1;
    for (int m = 0; m < 3; m++)
    begin
      apb(1'b1, hcs_pkg::OFF_GCFG, (m == 0) ? 32'h8 : (m == 1) ? 32'h5 : 32'h2);
      repeat (2) @(posedge clk_in);
      chk("irqa", 32'(m != 0), 32'(irq_a_out));
      chk("irqb", 32'(m != 1), 32'(irq_b_out));
      for (int g = 0; g < 8; g++)
        chk("port", g >> m, 32'(grp_port_out[3*g +: 3]));
    end
    for (int g = 0; g < 8; g++)
    begin
      apb(1'b1, hcs_pkg::OFF_GBASE0 + 12'(4*g), (32'hFFFFFFFF << (g + 11)) | 32'h7FF);
      apb(1'b0, hcs_pkg::OFF_GBASE0 + 12'(4*g), 0);
      chk("gbase", 32'hFFFFFFFF << (g + 11), rd);
      chk("desc", 32'hFFFFFFFF << (g + 11), grp_desc_addr_out[32*g +: 32]);
    end
    mst(32'h00000000);
    mst(32'h0000A5C3);
    for (int i = 0; i < 2; i++)
    begin
      tgt_addr_phase_in <= 1'b1;
      tgt_cbe_in <= (i == 0) ? hcs_pkg::PCI_CMD_DAC : 4'h6;
      @(posedge clk_in);
      tgt_addr_phase_in <= 1'b0;
      @(posedge clk_in);
      chk("claim", i, 32'(tgt_claim_out));
    end
    for (int i = 0; i < 8; i++)
      apb(1'b1, hcs_pkg::OFF_SREQ0 + 12'(4*i), {19'h0, ops[i], 8'h00});
    for (n = 0; n < 60 && acks !== 8'hFF; n++) @(posedge clk_in);
    chk("acks", 32'hFF, 32'(acks));
    chk("ackn", 8, ackn);
    chk("opcode", 32'(hcs_pkg::OP_JUMP), 32'(grp_cmd_opcode_out));
    apb(1'b1, hcs_pkg::OFF_SREQ0 + 12'h00C, 32'h00000100);
    repeat (6) @(posedge clk_in);
    apb(1'b0, hcs_pkg::OFF_GCFG, 0);
    chk("rstcfg", 0, rd);
    chk("srst", 1, srst);
    chk("ackn", 8, ackn);
    apb(1'b1, hcs_pkg::OFF_GCFG, 32'h00000630);
    eb_start_in <= 1'b1;
    @(posedge clk_in);
    eb_start_in <= 1'b0;
    while (eb_ad_oe_n_out !== 1'b0) @(posedge clk_in);
    for (n = 0; n < 40 && eb_addr_strobe_n_out !== 1'b0; n++) @(posedge clk_in);
    chk("astretch", 3 * hcs_pkg::EBUS_DIV, n);
    chk("rwn", 1, 32'(eb_rw_n_out));
    for (n = 0; n < 40 && eb_wr_n_out !== 1'b0; n++) @(posedge clk_in);
    chk("dstretch", 4 * hcs_pkg::EBUS_DIV, n);
    chk("wdata", 32'h0000005A, eb_ad_out);
    chk("dsn", 1, 32'(eb_ds_n_out));
    while (eb_done_out !== 1'b1) @(posedge clk_in);
    apb(1'b1, hcs_pkg::OFF_GCFG, 0);
    eb_write_in <= 1'b0;
    eb_ad_in <= 32'hC3A50F1E;
    eb_start_in <= 1'b1;
    @(posedge clk_in);
    eb_start_in <= 1'b0;
    while (eb_ds_n_out !== 1'b0) @(posedge clk_in);
    chk("rwn", 1, 32'(eb_rw_n_out));
    chk("req", 1, 32'(eb_req_out));
    while (eb_done_out !== 1'b1) @(posedge clk_in);
    chk("rdata", 32'hC3A50F1E, eb_rdata_out);
    tally_and_finish();
  end
endmodule : test_host_config_and_service_requests
